// [hdl/eecc_ctrl.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - the 3-bit command field selects read, disable, enable, write, write-all, erase, erase-all or reload.
// - writing one to busy starts the command, busy stays set until it ends, and the host leaves the registers alone.
// - busy reads set after reset while the station address load is tried, then clears.
// - write sends the data byte to the addressed location.
// - write-all sends the data byte to every location.
// - erase-all starts a bulk erase of the whole memory.
// - reload rereads the station address and fails unless location zero holds A5h.
// - the read-only loaded flag at bit 8 sets when a station address load succeeds.
// - no ready answer within 30 ms abandons the command and sets the timeout flag at bit 9, cleared by the host.
// - with the data pin pulled high and no memory, commands never time out and busy clears after the sequence.
// - the 8-bit address field in bits 7-0 resets to 00h and addresses a byte location.
// - the data register keeps the last byte read or the byte to write in bits 7:0, upper bits read zero.
module eecc_ctrl #(
  parameter int TIMEOUT_CYC = eecc_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire eecc_pkg::eecc_bus_req_t busReq,
  output logic [31:0] regRdata,
  output logic irq,
  output eecc_pkg::eecc_pins_t eePins,
  input wire logic eeDataIn,
  output logic [8*eecc_pkg::STA_BYTES-1:0] stationAddr,
  output logic stationAddrLoaded
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [eecc_pkg::FRAME_W-1:0] frameFor(
    eecc_pkg::eecc_cmd_t c, logic [7:0] a, logic [7:0] d);
    case (c)
      eecc_pkg::CMD_READ, eecc_pkg::CMD_RELOAD: frameFor = {3'h6, a, 8'h00};
      eecc_pkg::CMD_EW_DISABLE: frameFor = {3'h4, 8'h00, 8'h00};
      eecc_pkg::CMD_EW_ENABLE: frameFor = {3'h4, 8'hC0, 8'h00};
      eecc_pkg::CMD_WRITE: frameFor = {3'h5, a, d};
      eecc_pkg::CMD_WRITE_ALL: frameFor = {3'h4, 8'h40, d};
      eecc_pkg::CMD_ERASE: frameFor = {3'h7, a, 8'h00};
      eecc_pkg::CMD_ERASE_ALL: frameFor = {3'h4, 8'h80, 8'h00};
      default: frameFor = '0;
    endcase
  endfunction : frameFor

  // only commands that program the array wait for a ready answer
  function automatic logic waitsReady(eecc_pkg::eecc_cmd_t c);
    waitsReady = (c == eecc_pkg::CMD_WRITE) || (c == eecc_pkg::CMD_WRITE_ALL) ||
                 (c == eecc_pkg::CMD_ERASE) || (c == eecc_pkg::CMD_ERASE_ALL);
  endfunction : waitsReady

  function automatic logic [4:0] frameLen(eecc_pkg::eecc_cmd_t c);
    frameLen = ((c == eecc_pkg::CMD_WRITE) || (c == eecc_pkg::CMD_WRITE_ALL)) ?
               5'(eecc_pkg::FRAME_W) : 5'(eecc_pkg::FRAME_SHORT);
  endfunction : frameLen

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int TO_W = eecc_pkg::TO_W;

  eecc_pkg::eecc_regs_t s_q;
  eecc_pkg::eecc_regs_t s_d;

  always_comb begin
    logic tick;
    logic doneEv;
    logic toEv;
    logic [7:0] rxByte;
    eecc_pkg::eecc_cmd_t curCmd;
    logic [7:0] curAddr;
    logic [eecc_pkg::FRAME_W-1:0] frame;
    s_d = s_q;
    tick = (s_q.divCnt == 8'(eecc_pkg::SK_HALF_CYC - 1));
    doneEv = 1'b0;
    toEv = 1'b0;
    rxByte = {s_q.rx[6:0], s_q.sync2};
    curCmd = s_q.reloading ? eecc_pkg::CMD_READ : s_q.cmd;
    curAddr = s_q.reloading ? {5'h00, s_q.idx} : s_q.addr;
    frame = frameFor(curCmd, curAddr, s_q.data);
    s_d.sync1 = eeDataIn;
    s_d.sync2 = s_q.sync1;
    s_d.divCnt = tick ? 8'h00 : s_q.divCnt + 8'h01;
    s_d.rdata = 32'h0000_0000;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    if (busReq.rd) begin
      case (busReq.addr)
        eecc_pkg::CMD_CTRL_OFS: begin
          s_d.rdata[eecc_pkg::BUSY_BIT] = s_q.busy;
          s_d.rdata[eecc_pkg::CMD_LSB +: 3] = s_q.cmd;
          s_d.rdata[eecc_pkg::TIMEOUT_BIT] = s_q.timeout;
          s_d.rdata[eecc_pkg::LOADED_BIT] = s_q.loaded;
          s_d.rdata[7:0] = s_q.addr;
        end
        eecc_pkg::DATA_BYTE_OFS: s_d.rdata[7:0] = s_q.data;
        eecc_pkg::IRQ_STAT_OFS: s_d.rdata[eecc_pkg::IRQ_W-1:0] = s_q.irqStat;
        eecc_pkg::IRQ_MASK_OFS: s_d.rdata[eecc_pkg::IRQ_W-1:0] = s_q.irqMask;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (busReq.wr) begin
      case (busReq.addr)
        eecc_pkg::CMD_CTRL_OFS: begin
          if (busReq.wdata[eecc_pkg::TIMEOUT_BIT]) begin
            s_d.timeout = 1'b0;
          end
          // while busy only the timeout clear of a write is taken, so the running frame stays intact
          if (!s_q.busy) begin
            s_d.addr = busReq.wdata[7:0];
            s_d.cmd = eecc_pkg::eecc_cmd_t'(busReq.wdata[eecc_pkg::CMD_LSB +: 3]);
            if (busReq.wdata[eecc_pkg::BUSY_BIT]) begin
              s_d.busy = 1'b1;
              s_d.state = eecc_pkg::ST_START;
              s_d.divCnt = 8'h00;
              s_d.pins.cs = 1'b1;
              s_d.idx = 3'h0;
              s_d.reloading = (s_d.cmd == eecc_pkg::CMD_RELOAD);
              if (s_d.cmd == eecc_pkg::CMD_RELOAD) begin
                s_d.loaded = 1'b0;
              end
            end
          end
        end
        eecc_pkg::DATA_BYTE_OFS: begin
          if (!s_q.busy) begin
            s_d.data = busReq.wdata[7:0];
          end
        end
        eecc_pkg::IRQ_STAT_OFS: s_d.irqStat = s_q.irqStat & ~busReq.wdata[eecc_pkg::IRQ_W-1:0];
        eecc_pkg::IRQ_MASK_OFS: s_d.irqMask = busReq.wdata[eecc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // ----------------------------------------
    // serial sequencer
    // ----------------------------------------
    case (s_q.state)
      eecc_pkg::ST_IDLE: ;
      eecc_pkg::ST_START: begin
        s_d.pins.cs = 1'b1;
        s_d.pins.sk = 1'b0;
        if (tick) begin
          s_d.shift = frame << 1;
          s_d.pins.dataOut = frame[eecc_pkg::FRAME_W-1];
          s_d.pins.dataOe = 1'b1;
          s_d.bitCnt = frameLen(curCmd);
          s_d.state = eecc_pkg::ST_SHIFT;
        end
      end
      eecc_pkg::ST_SHIFT: begin
        if (tick) begin
          s_d.pins.sk = ~s_q.pins.sk;
          if (s_q.pins.sk) begin
            if (s_q.bitCnt == 5'h01) begin
              s_d.pins.dataOe = 1'b0;
              s_d.pins.dataOut = 1'b0;
              if (curCmd == eecc_pkg::CMD_READ) begin
                s_d.rxCnt = 4'(eecc_pkg::RX_BITS);
                s_d.state = eecc_pkg::ST_RECV;
              end else if (waitsReady(curCmd)) begin
                s_d.pins.cs = 1'b0;
                s_d.state = eecc_pkg::ST_GAP;
              end else begin
                s_d.state = eecc_pkg::ST_FINISH;
              end
            end else begin
              s_d.pins.dataOut = s_q.shift[eecc_pkg::FRAME_W-1];
              s_d.shift = s_q.shift << 1;
              s_d.bitCnt = s_q.bitCnt - 5'h01;
            end
          end
        end
      end
      eecc_pkg::ST_RECV: begin
        if (tick) begin
          s_d.pins.sk = ~s_q.pins.sk;
          // sampled at the end of the high phase, well after the memory drives
          if (s_q.pins.sk) begin
            s_d.rx = rxByte;
            s_d.rxCnt = s_q.rxCnt - 4'h1;
            if (s_q.rxCnt == 4'h1) begin
              s_d.state = eecc_pkg::ST_FINISH;
              if (!s_q.reloading) begin
                s_d.data = rxByte;
              end else if (s_q.idx == 3'h0) begin
                if (rxByte == eecc_pkg::SIGNATURE_BYTE) begin
                  s_d.idx = 3'h1;
                  s_d.pins.cs = 1'b0;
                  s_d.state = eecc_pkg::ST_NEXT;
                end
              end else begin
                s_d.staAddr[8*(32'(s_q.idx) - 1) +: 8] = rxByte;
                if (s_q.idx == 3'(eecc_pkg::STA_BYTES)) begin
                  s_d.loaded = 1'b1;
                end else begin
                  s_d.idx = s_q.idx + 3'h1;
                  s_d.pins.cs = 1'b0;
                  s_d.state = eecc_pkg::ST_NEXT;
                end
              end
            end
          end
        end
      end
      eecc_pkg::ST_NEXT: begin
        if (tick) begin
          s_d.pins.cs = 1'b1;
          s_d.state = eecc_pkg::ST_START;
        end
      end
      eecc_pkg::ST_GAP: begin
        if (tick) begin
          s_d.pins.cs = 1'b1;
          s_d.toCnt = '0;
          s_d.state = eecc_pkg::ST_WAIT;
        end
      end
      eecc_pkg::ST_WAIT: begin
        s_d.toCnt = s_q.toCnt + 1'b1;
        if (s_q.sync2) begin
          s_d.state = eecc_pkg::ST_FINISH;
        end else if (s_q.toCnt == TO_W'(TIMEOUT_CYC - 1)) begin
          s_d.timeout = 1'b1;
          toEv = 1'b1;
          s_d.state = eecc_pkg::ST_FINISH;
        end
      end
      eecc_pkg::ST_FINISH: begin
        s_d.pins = '0;
        s_d.busy = 1'b0;
        s_d.reloading = 1'b0;
        doneEv = 1'b1;
        s_d.state = eecc_pkg::ST_IDLE;
      end
      default: s_d.state = eecc_pkg::ST_IDLE;
    endcase

    // set wins over a clear in the same cycle
    s_d.irqStat[eecc_pkg::IRQ_DONE_BIT] = s_d.irqStat[eecc_pkg::IRQ_DONE_BIT] | doneEv;
    s_d.irqStat[eecc_pkg::IRQ_TO_BIT] = s_d.irqStat[eecc_pkg::IRQ_TO_BIT] | toEv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= eecc_pkg::ST_START;
      s_q.busy <= 1'b1;
      s_q.reloading <= 1'b1;
      s_q.pins.cs <= 1'b1;
      s_q.addr <= eecc_pkg::ADDR_RST;
      s_q.data <= eecc_pkg::DATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = s_q.rdata;
  assign irq = |(s_q.irqStat & s_q.irqMask);
  assign eePins = s_q.pins;
  assign stationAddr = s_q.staAddr;
  assign stationAddrLoaded = s_q.loaded;

endmodule : eecc_ctrl

// [common/eecc_pkg.sv]
package eecc_pkg;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [7:0] CMD_CTRL_OFS = 8'hB0;
  localparam logic [7:0] DATA_BYTE_OFS = 8'hB4;
  localparam logic [7:0] IRQ_STAT_OFS = 8'hB8;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hBC;
  localparam int BUSY_BIT = 31;
  localparam int CMD_LSB = 28;
  localparam int TIMEOUT_BIT = 9;
  localparam int LOADED_BIT = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TO_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] SIGNATURE_BYTE = 8'hA5;
  localparam int STA_BYTES = 6;

  // ----------------------------------------
  // serial framing and timing
  // ----------------------------------------
  localparam int FRAME_W = 19;
  localparam int FRAME_SHORT = 11;
  localparam int RX_BITS = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SK_HALF_NS = 80;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TO_W = 22;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_READ, CMD_EW_DISABLE, CMD_EW_ENABLE, CMD_WRITE,
    CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL, CMD_RELOAD
  } eecc_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SHIFT, ST_RECV, ST_GAP, ST_WAIT, ST_NEXT, ST_FINISH
  } eecc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } eecc_bus_req_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic dataOut;
    logic dataOe;
  } eecc_pins_t;

  typedef struct packed {
    eecc_state_t state;
    logic [7:0] divCnt;
    eecc_pins_t pins;
    logic [FRAME_W-1:0] shift;
    logic [4:0] bitCnt;
    logic [3:0] rxCnt;
    logic [7:0] rx;
    eecc_cmd_t cmd;
    logic [7:0] addr;
    logic [7:0] data;
    logic busy;
    logic timeout;
    logic loaded;
    logic reloading;
    logic [2:0] idx;
    logic [TO_W-1:0] toCnt;
    logic [8*STA_BYTES-1:0] staAddr;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [31:0] rdata;
    logic sync1;
    logic sync2;
  } eecc_regs_t;

endpackage : eecc_pkg

// [verif/eecc_ctrl_checker.sv]
`timescale 1ns/10ps
// ----------------------------------------
// pin and bus checks
// ----------------------------------------
module eecc_ctrl_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire eecc_pkg::eecc_bus_req_t busReq,
  input wire logic [31:0] regRdata,
  input wire logic irq,
  input wire eecc_pkg::eecc_pins_t eePins,
  input wire logic eeDataIn,
  input wire logic [8*eecc_pkg::STA_BYTES-1:0] stationAddr,
  input wire logic stationAddrLoaded
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence skLow8; !eePins.sk [*8]; endsequence
  sequence skHigh8; eePins.sk [*8]; endsequence
  AST_START_LEN: assert property ($rose(eePins.cs) |-> skLow8) else $error("start phase short");
  AST_SK_HIGH: assert property ($rose(eePins.sk) |-> skHigh8) else $error("sk high phase short");
  AST_DOUT_HOLD: assert property (eePins.sk |-> $stable(eePins.dataOut)) else $error("data moved, sk high");
  AST_OE_CS: assert property (!eePins.cs |-> !eePins.dataOe) else $error("pin driven, no select");
  AST_RST_BUSY: assert property ($fell(rst) |-> eePins.cs && !eePins.sk) else $error("no load after reset");
  AST_RD_IDLE: assert property (!$past(busReq.rd) |-> regRdata == 32'h0) else $error("read data not idle");
  AST_RSVD: assert property ($past(busReq.rd) && $past(busReq.addr) == eecc_pkg::DATA_BYTE_OFS
    |-> regRdata[31:8] == 24'h0) else $error("reserved data bits set");
  AST_CMD_START: assert property (busReq.wr && busReq.addr == eecc_pkg::CMD_CTRL_OFS && busReq.wdata[31]
    && !eePins.cs |=> eePins.cs) else $error("command did not start");
endmodule : eecc_ctrl_checker
bind eecc_ctrl eecc_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.clk(clk), .rst(rst), .busReq(busReq),
  .regRdata(regRdata), .irq(irq), .eePins(eePins), .eeDataIn(eeDataIn), .stationAddr(stationAddr),
  .stationAddrLoaded(stationAddrLoaded));

// [verif/eecc_mem_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// serial memory
// ----------------------------------------
module eecc_mem_model (
  input wire logic cs,
  input wire logic sk,
  input wire logic pin,
  input wire logic off,
  output logic drv,
  output logic dq
);
  logic [7:0] mem [256];
  logic [18:0] sh;
  logic en = 1'b0; // powers up write-protected
  logic rdm;
  int n;
  initial begin
    drv = 1'b0;
    dq = 1'b0;
    foreach (mem[i]) mem[i] = (i < 7) ? 8'h10 + 8'(i) : 8'h00;
    mem[0] = 8'hA5;
  end
  always @(posedge cs) begin
    n = 0;
    rdm = 1'b0;
    drv = !off; // ready at once; off leaves the line to its pull
    dq = 1'b1;
  end
  always @(posedge sk) begin
    if (n == 11) rdm = sh[9:8] == 2'b10;
    if (rdm) dq = mem[sh[7:0]][18 - n];
    else sh = {sh[17:0], pin};
    n++;
  end
  always @(negedge cs) begin
    if (en && !rdm && n == 19 && sh[17:16] == 2'b01) mem[sh[15:8]] = sh[7:0];
    if (en && !rdm && n == 19 && sh[17:14] == 4'b0001) foreach (mem[i]) mem[i] = sh[7:0];
    if (en && n == 11 && sh[9:8] == 2'b11) mem[sh[7:0]] = 8'hFF;
    if (en && n == 11 && sh[9:6] == 4'b0010) foreach (mem[i]) mem[i] = 8'hFF;
    if (n == 11 && sh[9:6] == 4'b0011) en = 1'b1;
    if (n == 11 && sh[9:6] == 4'b0000) en = 1'b0;
    drv = 1'b0;
  end
endmodule : eecc_mem_model

// [verif/eecc_ctrl_bench.sv]
`timescale 1ns/10ps
// ----------------------------------------
// bench
// ----------------------------------------
module eecc_ctrl_bench;
  logic clk;
  logic rst = 1'b1;
  eecc_pkg::eecc_bus_req_t busReq = '0;
  logic [31:0] regRdata;
  logic irq;
  eecc_pkg::eecc_pins_t eePins;
  logic [47:0] stationAddr;
  logic stationAddrLoaded;
  logic memOff = 1'b0;
  logic pullHigh = 1'b1;
  logic memDrv;
  logic memBit;
  logic pin;
  logic [31:0] v;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  assign pin = eePins.dataOe ? eePins.dataOut : (memDrv ? memBit : pullHigh);
  eecc_ctrl #(.TIMEOUT_CYC(200)) i_dut (.clk(clk), .rst(rst), .busReq(busReq), .regRdata(regRdata), .irq(irq),
    .eePins(eePins), .eeDataIn(pin), .stationAddr(stationAddr), .stationAddrLoaded(stationAddrLoaded));
  eecc_mem_model i_mem (.cs(eePins.cs), .sk(eePins.sk), .pin(pin), .off(memOff), .drv(memDrv), .dq(memBit));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report;
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [47:0] e, input logic [47:0] g, input string what);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 v = regRdata;
    @(posedge clk);
  endtask : rd
  // leaves the command register's last read in v
  task automatic cmd(input eecc_pkg::eecc_cmd_t c, input logic [7:0] a);
    if (c != eecc_pkg::CMD_RELOAD || a != 8'hFF) wr(eecc_pkg::CMD_CTRL_OFS, {1'b1, c, 20'h0, a});
    v = 32'h8000_0000;
    for (int i = 0; i < 2000 && v[31] === 1'b1; i++) rd(eecc_pkg::CMD_CTRL_OFS);
    chk(1'b0, v[31], "busy");
  endtask : cmd
  task automatic rdmem(input logic [7:0] a, input logic [7:0] e);
    cmd(eecc_pkg::CMD_READ, a);
    rd(eecc_pkg::DATA_BYTE_OFS);
    chk({24'h0, e}, v, "byte");
  endtask : rdmem
  task automatic t_reset;
    wr(eecc_pkg::CMD_CTRL_OFS, 32'h0000_0033);
    rd(eecc_pkg::CMD_CTRL_OFS);
    chk(1'b1, v[31], "busy");
    chk(8'h00, v[7:0], "addr");
    wr(eecc_pkg::DATA_BYTE_OFS, 32'h77);
    rd(eecc_pkg::DATA_BYTE_OFS);
    chk(32'h0, v, "data");
    rd(8'hC0);
    chk(32'h0, v, "unmapped");
    cmd(eecc_pkg::CMD_RELOAD, 8'hFF);
    chk(1'b1, v[8], "loaded");
    chk(48'h161514131211, stationAddr, "station");
    chk(1'b1, stationAddrLoaded, "loaded pin");
  endtask : t_reset
  task automatic t_guard;
    wr(eecc_pkg::DATA_BYTE_OFS, 32'h5C);
    cmd(eecc_pkg::CMD_WRITE, 8'h20);
    rdmem(8'h20, 8'h00);
    wr(eecc_pkg::DATA_BYTE_OFS, 32'h5C);
    cmd(eecc_pkg::CMD_EW_ENABLE, 8'h00);
    cmd(eecc_pkg::CMD_WRITE, 8'h20);
    rdmem(8'h20, 8'h5C);
    cmd(eecc_pkg::CMD_ERASE, 8'h20);
    rdmem(8'h20, 8'hFF);
    rdmem(8'h21, 8'h00);
    rd(eecc_pkg::CMD_CTRL_OFS);
    chk(8'h21, v[7:0], "addr");
    chk(3'h0, v[30:28], "command");
  endtask : t_guard
  task automatic t_all;
    wr(eecc_pkg::DATA_BYTE_OFS, 32'h3C);
    cmd(eecc_pkg::CMD_WRITE_ALL, 8'h00);
    rdmem(8'hFF, 8'h3C);
    cmd(eecc_pkg::CMD_ERASE_ALL, 8'h00);
    rdmem(8'h40, 8'hFF);
    cmd(eecc_pkg::CMD_RELOAD, 8'h00);
    chk(1'b0, v[8], "loaded");
    wr(eecc_pkg::DATA_BYTE_OFS, 32'hA5);
    cmd(eecc_pkg::CMD_WRITE, 8'h00);
    cmd(eecc_pkg::CMD_EW_DISABLE, 8'h00);
    cmd(eecc_pkg::CMD_RELOAD, 8'h00);
    chk(1'b1, v[8], "loaded");
    chk(48'hFFFFFFFFFFFF, stationAddr, "station");
    wr(eecc_pkg::DATA_BYTE_OFS, 32'h00);
    cmd(eecc_pkg::CMD_WRITE, 8'h00);
    rdmem(8'h00, 8'hA5);
  endtask : t_all
  task automatic t_fault;
    wr(eecc_pkg::IRQ_MASK_OFS, 32'h2);
    memOff <= 1'b1;
    pullHigh <= 1'b0;
    cmd(eecc_pkg::CMD_WRITE, 8'h01);
    chk(1'b1, v[9], "timeout");
    rd(eecc_pkg::IRQ_STAT_OFS);
    chk(32'h3, v, "irq status");
    @(negedge clk) chk(1'b1, irq, "irq");
    @(posedge clk);
    wr(eecc_pkg::IRQ_STAT_OFS, 32'h3);
    @(negedge clk) chk(1'b0, irq, "irq");
    @(posedge clk);
    wr(eecc_pkg::CMD_CTRL_OFS, 32'h200);
    rdmem(8'h01, 8'h00);
    rd(eecc_pkg::CMD_CTRL_OFS);
    chk(1'b0, v[9], "timeout");
    pullHigh <= 1'b1;
    cmd(eecc_pkg::CMD_ERASE, 8'h01);
    chk(1'b0, v[9], "timeout");
    rdmem(8'h01, 8'hFF);
  endtask : t_fault
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_guard();
    t_all();
    t_fault();
    final_report();
  end
endmodule : eecc_ctrl_bench
